// ===== rtl/cmc_crc_monitor.sv
// Configuration memory CRC monitor with test access to the reference register
//
// Overview of operation
// R1: Check each frame CRC while loading; stop on mismatch
// R2: Frame mismatch drives configuration status low
// R3: End of loading stores 32-bit reference CRC
// R4: User mode rescans memory against reference repeatedly
// R5: Only reconfiguration request low stops the checking
// R6: Block memory and I/O data are excluded
// R7: One 32-bit CRC, IEEE 802 polynomial
// R8: Fault output high exactly when signature non-zero
// R9: Instruction 0x015 selects reference register as data
// R10: Reference access works only in user mode
// R11: Host saves correct reference before injecting error
// R12: Wrong reference raises fault; correct one clears
// R13: Restoring reference returns to normal checking
// R14: Checking runs only when option enabled
// R15: System reconfigures or ignores on fault
// R16: Fault updates only at end of pass; reconfiguration request low also clears it
`timescale 1ns/1ps
`default_nettype none
module cmc_crc_monitor
	import cmc_pkg::*;
#(
	parameter int MEM_WORDS = CMC_MEM_WORDS
) (
	input  wire logic          clock,
	input  wire logic          resetn,
	input  wire logic          reconfig_req_n,
	input  wire cmc_cfg_word_t cfg_word,
	input  wire cmc_upset_t    upset,
	input  wire cmc_jtag_in_t  jtag,
	output var  logic          tdo,
	output var  logic          tdo_oe,
	output var  logic          config_status_n,
	output var  logic          user_mode,
	output var  logic          integrity_fault
);

	localparam int AW = $clog2(MEM_WORDS);
	localparam int CW = $clog2(MEM_WORDS + 1);

	if (MEM_WORDS < 2 || MEM_WORDS > (1 << CMC_ADDR_W)) begin : g_check
		$error("MEM_WORDS out of range");
	end

	// ****************************************
	// CRC steps
	// ****************************************
	function automatic logic [31:0] crc32_step(input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? CMC_CRC32_POLY : 32'h00000000); // R7
		end
		return r;
	endfunction

	function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic [31:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CMC_FRAME_POLY : 16'h0000);
		end
		return r;
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [CMC_SYNC_STAGES-1:0] rc_sync_reg;
	logic [CMC_SYNC_STAGES-1:0] tck_sync_reg;
	logic [CMC_SYNC_STAGES-1:0] tms_sync_reg;
	logic [CMC_SYNC_STAGES-1:0] tdi_sync_reg;
	logic                       tck_last_reg;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			rc_sync_reg  <= '1;
			tck_sync_reg <= '0;
			tms_sync_reg <= '1;
			tdi_sync_reg <= '0;
			tck_last_reg <= 1'b0;
		end else begin
			rc_sync_reg  <= {rc_sync_reg[0], reconfig_req_n};
			tck_sync_reg <= {tck_sync_reg[0], jtag.tck};
			tms_sync_reg <= {tms_sync_reg[0], jtag.tms};
			tdi_sync_reg <= {tdi_sync_reg[0], jtag.tdi};
			tck_last_reg <= tck_sync_reg[1];
		end
	end

	wire rc_low   = ~rc_sync_reg[1];
	wire tck_rise = tck_sync_reg[1] & ~tck_last_reg;
	wire tck_fall = ~tck_sync_reg[1] & tck_last_reg;
	wire tms_s    = tms_sync_reg[1];
	wire tdi_s    = tdi_sync_reg[1];

	// ****************************************
	// State and storage
	// ****************************************
	cmc_state_t      state_reg;
	cmc_state_t      state_next;
	cmc_tap_t        tap_reg;
	cmc_tap_t        tap_next;
	logic [31:0]     cells [MEM_WORDS];
	logic [CW-1:0]   wcnt_reg;
	logic [CW-1:0]   scan_addr_reg;
	logic [31:0]     scan_crc_reg;
	logic [15:0]     frame_crc_reg;
	logic [31:0]     ref_crc_reg;
	logic [31:0]     ref_crc_next;
	logic            ed_enable_reg;
	logic            fault_reg;
	logic            status_n_reg;
	logic            user_mode_reg;
	logic [CMC_IR_LEN-1:0] ir_reg;
	logic [CMC_IR_LEN-1:0] ir_shift_reg;
	logic [31:0]     dr_shift_reg;
	logic            bypass_reg;
	logic            tdo_reg;
	logic            tdo_oe_reg;

	// ****************************************
	// Stream decode
	// ****************************************
	wire in_load    = state_reg == CMC_ST_LOAD;
	wire take_word  = in_load & cfg_word.valid & ~rc_low;
	wire take_data  = take_word & (cfg_word.kind == CMC_KIND_DATA);
	wire take_opt   = take_word & (cfg_word.kind == CMC_KIND_OPT);
	wire take_fcrc  = take_word & (cfg_word.kind == CMC_KIND_FCRC);
	wire take_ref   = take_word & (cfg_word.kind == CMC_KIND_REF);
	wire is_payload = take_word & (cfg_word.kind inside {CMC_KIND_DATA, CMC_KIND_AUX, CMC_KIND_OPT});
	wire frame_bad  = take_fcrc & (frame_crc_reg != cfg_word.data[15:0]);             // R1
	wire mem_room   = wcnt_reg < CW'(MEM_WORDS);
	wire cell_write = take_data & mem_room;                                              // R6
	wire upset_hit  = upset.valid & ({1'b0, upset.addr} < (CMC_ADDR_W + 1)'(MEM_WORDS));
	wire scan_more  = scan_addr_reg != wcnt_reg;
	wire [31:0] scan_word = cells[scan_addr_reg[AW-1:0]];
	wire [31:0] sig_fold  = crc32_step(scan_crc_reg, ref_crc_reg);
	wire in_user    = state_reg inside {CMC_ST_SCAN, CMC_ST_FOLD, CMC_ST_IDLE};
	wire user_mode_next = state_next inside {CMC_ST_SCAN, CMC_ST_FOLD, CMC_ST_IDLE};
	wire ref_sel    = (ir_reg == CMC_IR_REF_ACCESS) & in_user;                           // R9 R10
	wire upd_dr     = tck_rise & (tap_reg == CMC_TAP_UPDDR);
	wire jtag_write = upd_dr & ref_sel;
	wire tdo_src    = (tap_reg == CMC_TAP_SHIR) ? ir_shift_reg[0] :
	                  (ref_sel ? dr_shift_reg[0] : bypass_reg);

	assign ref_crc_next = take_ref   ? cfg_word.data :                                  // R3
	                      jtag_write ? dr_shift_reg  : ref_crc_reg;                        // R12 R13

	// ****************************************
	// Check sequencer
	// ****************************************
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CMC_ST_LOAD: begin
				if (frame_bad) begin
					state_next = CMC_ST_FAIL;
				end else if (take_ref) begin
					state_next = ed_enable_reg ? CMC_ST_SCAN : CMC_ST_IDLE;                   // R14
				end
			end
			CMC_ST_SCAN: begin
				if (!scan_more) begin
					state_next = CMC_ST_FOLD;
				end
			end
			CMC_ST_FOLD: state_next = CMC_ST_SCAN;                                          // R4
			CMC_ST_IDLE: state_next = CMC_ST_IDLE;
			CMC_ST_FAIL: state_next = CMC_ST_FAIL;
			default:     state_next = CMC_ST_LOAD;
		endcase
		if (rc_low) begin
			state_next = CMC_ST_LOAD;                                                       // R5
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_reg     <= CMC_ST_LOAD;
			wcnt_reg      <= '0;
			scan_addr_reg <= '0;
			scan_crc_reg  <= CMC_SCAN_SEED;
			frame_crc_reg <= CMC_FRAME_SEED;
			ref_crc_reg   <= CMC_REF_RESET;
			ed_enable_reg <= 1'b0;
			fault_reg     <= 1'b0;
			status_n_reg  <= 1'b1;
			user_mode_reg <= 1'b0;
		end else begin
			state_reg   <= state_next;
			user_mode_reg <= user_mode_next;
			ref_crc_reg <= ref_crc_next;
			if (rc_low) begin
				wcnt_reg      <= '0;
				scan_addr_reg <= '0;
				scan_crc_reg  <= CMC_SCAN_SEED;
				frame_crc_reg <= CMC_FRAME_SEED;
				ed_enable_reg <= 1'b0;
				fault_reg     <= 1'b0;
				status_n_reg  <= 1'b1;
			end else begin
				if (cell_write) begin
					wcnt_reg <= wcnt_reg + CW'(1);
				end
				if (is_payload) begin
					frame_crc_reg <= crc16_step(frame_crc_reg, cfg_word.data);
				end else if (take_fcrc) begin
					frame_crc_reg <= CMC_FRAME_SEED;
				end
				if (take_opt) begin
					ed_enable_reg <= cfg_word.data[CMC_OPT_ED_EN_BIT];                       // R14
				end
				if (frame_bad) begin
					status_n_reg <= 1'b0;                                                    // R2
				end
				if (state_reg == CMC_ST_SCAN && scan_more) begin
					scan_crc_reg  <= crc32_step(scan_crc_reg, scan_word);                    // R4
					scan_addr_reg <= scan_addr_reg + CW'(1);
				end else if (state_reg == CMC_ST_FOLD) begin
					fault_reg     <= |sig_fold;                                              // R8 R16
					scan_crc_reg  <= CMC_SCAN_SEED;
					scan_addr_reg <= '0;
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (cell_write) begin
			cells[wcnt_reg[AW-1:0]] <= cfg_word.data;
		end else if (upset_hit) begin
			cells[upset.addr[AW-1:0]] <= cells[upset.addr[AW-1:0]] ^ upset.mask;
		end
	end

	// ****************************************
	// Test access port
	// ****************************************
	always_comb begin
		tap_next = tap_reg;
		unique case (tap_reg)
			CMC_TAP_TLR:   tap_next = tms_s ? CMC_TAP_TLR   : CMC_TAP_RTI;
			CMC_TAP_RTI:   tap_next = tms_s ? CMC_TAP_SELDR : CMC_TAP_RTI;
			CMC_TAP_SELDR: tap_next = tms_s ? CMC_TAP_SELIR : CMC_TAP_CAPDR;
			CMC_TAP_CAPDR: tap_next = tms_s ? CMC_TAP_EX1DR : CMC_TAP_SHDR;
			CMC_TAP_SHDR:  tap_next = tms_s ? CMC_TAP_EX1DR : CMC_TAP_SHDR;
			CMC_TAP_EX1DR: tap_next = tms_s ? CMC_TAP_UPDDR : CMC_TAP_PADR;
			CMC_TAP_PADR:  tap_next = tms_s ? CMC_TAP_EX2DR : CMC_TAP_PADR;
			CMC_TAP_EX2DR: tap_next = tms_s ? CMC_TAP_UPDDR : CMC_TAP_SHDR;
			CMC_TAP_UPDDR: tap_next = tms_s ? CMC_TAP_SELDR : CMC_TAP_RTI;
			CMC_TAP_SELIR: tap_next = tms_s ? CMC_TAP_TLR   : CMC_TAP_CAPIR;
			CMC_TAP_CAPIR: tap_next = tms_s ? CMC_TAP_EX1IR : CMC_TAP_SHIR;
			CMC_TAP_SHIR:  tap_next = tms_s ? CMC_TAP_EX1IR : CMC_TAP_SHIR;
			CMC_TAP_EX1IR: tap_next = tms_s ? CMC_TAP_UPDIR : CMC_TAP_PAIR;
			CMC_TAP_PAIR:  tap_next = tms_s ? CMC_TAP_EX2IR : CMC_TAP_PAIR;
			CMC_TAP_EX2IR: tap_next = tms_s ? CMC_TAP_UPDIR : CMC_TAP_SHIR;
			CMC_TAP_UPDIR: tap_next = tms_s ? CMC_TAP_SELDR : CMC_TAP_RTI;
			default:       tap_next = CMC_TAP_TLR;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			tap_reg      <= CMC_TAP_TLR;
			ir_reg       <= CMC_IR_BYPASS;
			ir_shift_reg <= CMC_IR_CAPTURE;
			dr_shift_reg <= '0;
			bypass_reg   <= 1'b0;
			tdo_reg      <= 1'b0;
			tdo_oe_reg   <= 1'b0;
		end else begin
			if (tck_rise) begin
				tap_reg <= tap_next;
				unique case (tap_reg)
					CMC_TAP_TLR:   ir_reg <= CMC_IR_BYPASS;
					CMC_TAP_CAPIR: ir_shift_reg <= CMC_IR_CAPTURE;
					CMC_TAP_SHIR:  ir_shift_reg <= {tdi_s, ir_shift_reg[CMC_IR_LEN-1:1]};
					CMC_TAP_UPDIR: ir_reg <= ir_shift_reg;                                  // R9
					CMC_TAP_CAPDR: begin
						dr_shift_reg <= ref_sel ? ref_crc_reg : 32'h00000000;                 // R11
						bypass_reg   <= 1'b0;
					end
					CMC_TAP_SHDR: begin
						if (ref_sel) begin
							dr_shift_reg <= {tdi_s, dr_shift_reg[31:1]};
						end else begin
							bypass_reg <= tdi_s;
						end
					end
					default: ;
				endcase
			end
			if (tck_fall) begin
				tdo_reg    <= tdo_src;
				tdo_oe_reg <= (tap_reg == CMC_TAP_SHIR) | (tap_reg == CMC_TAP_SHDR);
			end
		end
	end

	assign tdo             = tdo_reg;
	assign tdo_oe          = tdo_oe_reg;
	assign config_status_n = status_n_reg;
	assign user_mode       = user_mode_reg;
	assign integrity_fault = fault_reg;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	a_fault_pass_end: assert property ($changed(fault_reg) |-> $past(state_reg) == CMC_ST_FOLD || $past(rc_low)) // R16
		else $error("fault changed outside pass end");
	a_fault_sig_value: assert property (state_reg == CMC_ST_FOLD && !rc_low |=> fault_reg == |$past(sig_fold)) // R8
		else $error("fault does not match signature");
	a_status_on_bad: assert property (frame_bad |=> !status_n_reg && state_reg == CMC_ST_FAIL) // R2
		else $error("frame mismatch not flagged");
	a_load_stays_stopped: assert property (state_reg == CMC_ST_FAIL && !rc_low |=> state_reg == CMC_ST_FAIL) // R1
		else $error("loading resumed after mismatch");
	a_ref_latched: assert property (take_ref |=> ref_crc_reg == $past(cfg_word.data)) // R3
		else $error("reference not stored at end of load");
	a_jtag_ref_write: assert property (jtag_write && !take_ref |=> ref_crc_reg == $past(dr_shift_reg)) // R10
		else $error("shifted reference not taken");
	a_scan_needs_enable: assert property (state_reg == CMC_ST_SCAN |-> ed_enable_reg) // R14
		else $error("scan without enable");
	a_reconfig_stops: assert property (rc_low |=> state_reg == CMC_ST_LOAD && !fault_reg) // R5
		else $error("reconfiguration did not stop checking");
	a_scan_advance: assert property (state_reg == CMC_ST_SCAN && scan_more && !rc_low
		|=> scan_addr_reg == CW'($past(scan_addr_reg) + 1'b1)) // R4
		else $error("scan address did not advance");

endmodule
`default_nettype wire

// ===== common/cmc_pkg.sv
// Shared constants, types and carriers of the configuration memory CRC monitor
`default_nettype none
package cmc_pkg;

	// ****************************************
	// Check polynomials and seeds
	// ****************************************
	localparam logic [31:0] CMC_CRC32_POLY  = 32'h04c11db7;
	localparam logic [15:0] CMC_FRAME_POLY  = 16'h1021;
	localparam logic [31:0] CMC_SCAN_SEED   = 32'h00000000;
	localparam logic [15:0] CMC_FRAME_SEED  = 16'h0000;
	localparam logic [31:0] CMC_REF_RESET   = 32'h00000000;

	// ****************************************
	// Test access port
	// ****************************************
	localparam int          CMC_IR_LEN        = 10;
	localparam logic [9:0]  CMC_IR_REF_ACCESS = 10'h015;
	localparam logic [9:0]  CMC_IR_BYPASS     = 10'h3ff;
	localparam logic [9:0]  CMC_IR_CAPTURE    = 10'h001;
	localparam int          CMC_SYNC_STAGES   = 2;

	// ****************************************
	// Configuration stream
	// ****************************************
	localparam int CMC_OPT_ED_EN_BIT = 0;
	localparam int CMC_ADDR_W        = 16;
	localparam int CMC_MEM_WORDS     = 64;

	typedef enum logic [2:0] {
		CMC_KIND_DATA = 3'h0,
		CMC_KIND_AUX  = 3'h1,
		CMC_KIND_OPT  = 3'h2,
		CMC_KIND_FCRC = 3'h3,
		CMC_KIND_REF  = 3'h4
	} cmc_kind_t;

	typedef struct packed {
		logic        valid;
		cmc_kind_t   kind;
		logic [31:0] data;
	} cmc_cfg_word_t;

	typedef struct packed {
		logic                  valid;
		logic [CMC_ADDR_W-1:0] addr;
		logic [31:0]           mask;
	} cmc_upset_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} cmc_jtag_in_t;

	// ****************************************
	// State encodings
	// ****************************************
	typedef enum logic [4:0] {
		CMC_ST_LOAD = 5'h01,
		CMC_ST_SCAN = 5'h02,
		CMC_ST_FOLD = 5'h04,
		CMC_ST_IDLE = 5'h08,
		CMC_ST_FAIL = 5'h10
	} cmc_state_t;

	typedef enum logic [15:0] {
		CMC_TAP_TLR    = 16'h0001,
		CMC_TAP_RTI    = 16'h0002,
		CMC_TAP_SELDR  = 16'h0004,
		CMC_TAP_CAPDR  = 16'h0008,
		CMC_TAP_SHDR   = 16'h0010,
		CMC_TAP_EX1DR  = 16'h0020,
		CMC_TAP_PADR   = 16'h0040,
		CMC_TAP_EX2DR  = 16'h0080,
		CMC_TAP_UPDDR  = 16'h0100,
		CMC_TAP_SELIR  = 16'h0200,
		CMC_TAP_CAPIR  = 16'h0400,
		CMC_TAP_SHIR   = 16'h0800,
		CMC_TAP_EX1IR  = 16'h1000,
		CMC_TAP_PAIR   = 16'h2000,
		CMC_TAP_EX2IR  = 16'h4000,
		CMC_TAP_UPDIR  = 16'h8000
	} cmc_tap_t;

endpackage
`default_nettype wire

// ===== bench/cmc_jtag_host.sv
// Test host model driving the test access port of the monitor
`timescale 1ns/1ps
`default_nettype none
module cmc_jtag_host
	import cmc_pkg::*;
#(
	parameter int HALF = 8
) (
	input  wire logic         clock,
	input  wire logic         tdo,
	output var  cmc_jtag_in_t jtag
);
	initial jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};

	// ****************************************
	// One test clock period, tdo taken before rise
	// ****************************************
	task automatic cyc(input logic tms, input logic tdi, output logic so);
		@(posedge clock);
		jtag.tck <= 1'b0;
		jtag.tms <= tms;
		jtag.tdi <= tdi;
		repeat (HALF) @(posedge clock);
		so = tdo;
		jtag.tck <= 1'b1;
		repeat (HALF - 1) @(posedge clock);
	endtask

	task automatic to_idle();
		logic s;
		repeat (5) cyc(1'b1, 1'b0, s);
		cyc(1'b0, 1'b0, s);
	endtask

	// ****************************************
	// Instruction and data scans from idle
	// ****************************************
	task automatic load_ir(input logic [9:0] ir);
		logic s;
		cyc(1'b1, 1'b0, s);
		cyc(1'b1, 1'b0, s);
		cyc(1'b0, 1'b0, s);
		cyc(1'b0, 1'b0, s);
		for (int i = 0; i < CMC_IR_LEN; i++) cyc(i == CMC_IR_LEN - 1, ir[i], s);
		cyc(1'b1, 1'b0, s);
		cyc(1'b0, 1'b0, s);
	endtask

	task automatic shift_dr(input logic [31:0] v, output logic [31:0] cap);
		logic s;
		cyc(1'b1, 1'b0, s);
		cyc(1'b0, 1'b0, s);
		cyc(1'b0, 1'b0, s);
		for (int i = 0; i < 32; i++) begin
			cyc(i == 31, v[i], s);
			cap[i] = s;
		end
		cyc(1'b1, 1'b0, s);
		cyc(1'b0, 1'b0, s);
	endtask

	// Reads the good reference out while the bad one goes in
	task automatic inject(input logic [31:0] bad, output logic [31:0] saved);
		to_idle();
		load_ir(CMC_IR_REF_ACCESS);
		shift_dr(bad, saved);
	endtask

	task automatic restore(input logic [31:0] good, output logic [31:0] old);
		shift_dr(good, old);
	endtask
endmodule
`default_nettype wire

// ===== bench/cmc_crc_monitor_tb_top.sv
// Self-checking testbench of the configuration memory CRC monitor
`timescale 1ns/1ps
`default_nettype none
module cmc_crc_monitor_tb_top
	import cmc_pkg::*;
;
	localparam int N = 4;
	localparam int P = N + 2;
	logic          clock;
	logic          resetn;
	logic          reconfig_req_n;
	cmc_cfg_word_t cfg_word;
	cmc_upset_t    upset;
	cmc_jtag_in_t  jtag;
	logic          tdo;
	logic          tdo_oe;
	logic          config_status_n;
	logic          user_mode;
	logic          integrity_fault;
	int            errors;
	int            checks;
	logic [31:0]   mem [N];
	logic [31:0]   ref_crc;
	logic          oe_seen;

	cmc_crc_monitor #(.MEM_WORDS(N)) i_dut (
		.clock           (clock),
		.resetn          (resetn),
		.reconfig_req_n  (reconfig_req_n),
		.cfg_word        (cfg_word),
		.upset           (upset),
		.jtag            (jtag),
		.tdo             (tdo),
		.tdo_oe          (tdo_oe),
		.config_status_n (config_status_n),
		.user_mode       (user_mode),
		.integrity_fault (integrity_fault)
	);

	cmc_jtag_host i_host (
		.clock (clock),
		.tdo   (tdo),
		.jtag  (jtag)
	);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Remembers that the test data output was ever enabled
	always @(posedge clock) begin
		if (tdo_oe === 1'b1) begin
			oe_seen <= 1'b1;
		end
	end

	// ****************************************
	// Reference checksums and helpers
	// ****************************************
	function automatic logic [15:0] crc16(input logic [15:0] c, input logic [31:0] w);
		for (int i = 31; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? CMC_FRAME_POLY : 16'h0000);
		return c;
	endfunction

	function automatic logic [31:0] crc32(input logic [31:0] c, input logic [31:0] w);
		for (int i = 31; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i]) ? CMC_CRC32_POLY : 32'h00000000);
		return c;
	endfunction

	task automatic chk(input logic ok, input string msg);
		checks++;
		if (!ok) begin
			errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic send(input cmc_kind_t k, input logic [31:0] d);
		@(posedge clock);
		cfg_word <= '{valid: 1'b1, kind: k, data: d};
	endtask

	task automatic load(input logic en, input logic [15:0] fbad);
		logic [15:0] f;
		f = CMC_FRAME_SEED;
		ref_crc = CMC_SCAN_SEED;
		for (int i = 0; i < N; i++) begin
			send(CMC_KIND_DATA, mem[i]);
			f = crc16(f, mem[i]);
			ref_crc = crc32(ref_crc, mem[i]);
		end
		send(CMC_KIND_AUX, 32'h5a5a0f0f);
		send(CMC_KIND_OPT, {31'h0, en});
		f = crc16(crc16(f, 32'h5a5a0f0f), {31'h0, en});
		send(CMC_KIND_FCRC, {16'h0, f ^ fbad});
		send(CMC_KIND_REF, ref_crc);
		@(posedge clock);
		cfg_word.valid <= 1'b0;
		cycles(2);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_locked();
		logic [31:0] got;
		i_host.to_idle();
		i_host.load_ir(CMC_IR_REF_ACCESS);
		i_host.shift_dr(32'hc3a51e69, got);
		chk(got === 32'h874a3cd2, "locked access not bypassed");
		chk(oe_seen === 1'b1 && tdo_oe === 1'b0, "output enable not driven in shift");
	endtask

	task automatic t_clean();
		load(1'b1, 16'h0000);
		chk(user_mode === 1'b1 && config_status_n === 1'b1, "load not accepted");
		cycles(3 * P);
		chk(integrity_fault === 1'b0, "fault on clean memory");
	endtask

	task automatic t_inject();
		logic [31:0] saved;
		logic [31:0] got;
		i_host.inject(~ref_crc, saved);
		chk(saved === ref_crc, "reference readback");
		cycles(2 * P);
		chk(integrity_fault === 1'b1, "wrong reference not flagged");
		i_host.restore(saved, got);
		chk(got === ~ref_crc, "reference write lost");
		cycles(2 * P);
		chk(integrity_fault === 1'b0, "restore did not clear");
	endtask

	task automatic t_upset(input logic en);
		int hit;
		hit = -1;
		@(posedge clock);
		upset <= '{valid: 1'b1, addr: 16'h0002, mask: 32'h00000100};
		@(posedge clock);
		upset.valid <= 1'b0;
		for (int i = 0; i < 3 * P; i++) begin
			cycles(1);
			if (integrity_fault === 1'b1 && hit < 0) hit = i;
		end
		if (en) begin
			chk(hit >= 0 && hit <= 2 * P, "upset not flagged");
			chk(integrity_fault === 1'b1, "fault did not hold");
		end else
			chk(hit < 0 && user_mode === 1'b1, "checking while disabled");
	endtask

	task automatic t_reconfig();
		@(posedge clock);
		reconfig_req_n <= 1'b0;
		cycles(5);
		chk(user_mode === 1'b0 && integrity_fault === 1'b0, "checking not stopped");
		chk(config_status_n === 1'b1, "status not released");
		@(posedge clock);
		reconfig_req_n <= 1'b1;
		cycles(4);
	endtask

	task automatic t_frame();
		load(1'b1, 16'h0001);
		cycles(2);
		chk(config_status_n === 1'b0 && user_mode === 1'b0, "frame mismatch missed");
	endtask

	initial begin
		resetn = 1'b0;
		reconfig_req_n = 1'b1;
		cfg_word = '0;
		upset = '0;
		oe_seen = 1'b0;
		errors = 0;
		checks = 0;
		mem = '{32'h01234567, 32'h89abcdef, 32'h7e3c1a55, 32'h0f1e2d3c};
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		cycles(2);
		chk(user_mode === 1'b0 && integrity_fault === 1'b0 && tdo_oe === 1'b0, "reset state");
		t_locked();
		t_clean();
		t_inject();
		t_upset(1'b1);
		t_reconfig();
		t_frame();
		t_reconfig();
		load(1'b0, 16'h0000);
		t_upset(1'b0);
		tally_and_finish();
	end

	initial begin
		repeat (40000) @(posedge clock);
		errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule
`default_nettype wire
